//--- output_channel_divider_pkg.sv
// Shared constants and types for the output channel divider block
package output_channel_divider_pkg;

	// Register indices; the APB byte address is four times the index
	localparam logic [9:0]  IDX_CH1_ROUTE_DCC    = 10'h195;
	localparam logic [9:0]  IDX_CH2_PHASE_LENGTHS = 10'h196;
	localparam logic [9:0]  IDX_CH2_DIVIDER_CONTROL = 10'h197;
	localparam logic [9:0]  IDX_CH2_ROUTE_DCC    = 10'h198;
	localparam logic [9:0]  IDX_INPUT_SELECT     = 10'h1e1;
	localparam logic [9:0]  IDX_ALIGN_CONTROL    = 10'h1f0;
	localparam logic [9:0]  IDX_DIVIDER_STATUS   = 10'h1f1;

	// Field positions
	localparam int ROUTE_DIRECT_BIT  = 1;
	localparam int ROUTE_DCC_OFF_BIT = 0;
	localparam int CTL_BYPASS_BIT    = 7;
	localparam int CTL_NOALIGN_BIT   = 6;
	localparam int CTL_FORCE_BIT     = 5;
	localparam int CTL_START_BIT     = 4;
	localparam int LEN_LOW_MSB       = 7;
	localparam int LEN_LOW_LSB       = 4;
	localparam int LEN_HIGH_MSB      = 3;
	localparam int LEN_HIGH_LSB      = 0;
	localparam int CTL_PHASE_MSB     = 3;
	localparam int CTL_PHASE_LSB     = 0;
	localparam int INSEL_VCO_BIT     = 1;
	localparam int INSEL_BYP_BIT     = 0;

	// Reset values
	localparam logic [7:0] RST_ROUTE_DCC = 8'h00;
	localparam logic [7:0] RST_LENGTHS   = 8'h00;
	localparam logic [7:0] RST_CONTROL   = 8'h00;
	localparam logic [1:0] RST_INSEL     = 2'h0;
	localparam logic       RST_ALIGN     = 1'b0;

	// Input select codes that enable the direct route
	localparam logic [1:0] INSEL_DIRECT_VCO = 2'h2;
	localparam logic [1:0] INSEL_DIRECT_CLK = 2'h0;

	// Divider sequencer states, one-hot
	typedef enum logic [3:0] {
		DIV_HOLD = 4'h1,
		DIV_WAIT = 4'h2,
		DIV_LOW  = 4'h4,
		DIV_HIGH = 4'h8
	} div_state_t;

	// Complementary output pair
	typedef struct packed {
		logic a;
		logic b;
	} out_pair_t;

	// Whole state of the top module
	typedef struct packed {
		logic [7:0]  ch1_route_dcc;
		logic [7:0]  ch2_phase_lengths;
		logic [7:0]  ch2_divider_control;
		logic [7:0]  ch2_route_dcc;
		logic [1:0]  input_select;
		logic        align_hold;
		div_state_t  div_state;
		logic [3:0]  div_cnt;
		logic        div_out;
		out_pair_t   pair1;
		out_pair_t   pair2;
		logic [1:0]  dcc_disable;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} block_state_t;

endpackage

//--- output_channel_divider.sv
// Output channel dividers, direct routes and their APB register file
//
// Function
// - Direct bit clear: pair one from divider
// - Direct bit set: VCO, clock, or none
// - Bit zero disables duty-cycle correction
// - Low phase lasts field plus one
// - High phase lasts field plus one
// - Bypass passes divider input straight out
// - Exempt divider ignores the alignment signal
// - Force level applies only when exempt
// - Force ignored while divider is bypassed
// - Start bit picks first toggling level
// - Four-bit phase offset delays the output
// - Direct bit routes pair two likewise
// - Input select chooses VCO, bypass exclusive
// - Alignment holds; falling soft bit triggers
`timescale 1ns/1ps

module output_channel_divider (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        vco_in,
	input  wire logic        clk_in,
	input  wire logic        vco_div_in,
	input  wire logic        ch1_div_in,
	output logic             pair1_out_a,
	output logic             pair1_out_b,
	output logic             pair2_out_a,
	output logic             pair2_out_b,
	output logic [1:0]       duty_correction_disable
);

	// Registered state and its next value
	output_channel_divider_pkg::block_state_t state_r;
	output_channel_divider_pkg::block_state_t state_nxt;

	// Decoded access controls
	logic       setup_phase;   // First cycle of an APB transfer
	logic       write_commit;  // Write takes effect this edge
	logic [9:0] reg_index;     // Word index from the byte address
	logic       addr_aligned;  // Low address bits are zero

	// Field views of the channel two registers
	logic [3:0] low_len;       // Low phase length minus one
	logic [3:0] high_len;      // High phase length minus one
	logic [3:0] phase_off;     // Phase offset in pclk cycles
	logic       bypass;        // Divider bypassed
	logic       no_align;      // Divider exempt from alignment
	logic       force_high;    // Static level when exempt
	logic       start_high;    // First level after release
	logic       held;          // Alignment hold applies to divider
	logic       src_level;     // Divider input level
	logic       route_vco;     // Select code routes the VCO
	logic       route_clk;     // Select code routes the clock input
	logic [3:0] phase_last;    // Last count of the offset wait
	logic [7:0] wbyte;         // Write data low byte
	logic [1:0] insel_wr;      // Input select after exclusivity fix
	logic       div_level;     // Divider output from next state

	// Bus phase decode
	always_comb begin
		setup_phase  = psel && !penable;
		write_commit = psel && penable && pwrite && state_r.pready;
		reg_index    = paddr[11:2];
		addr_aligned = (paddr[1:0] == 2'h0);
		wbyte        = pwdata[7:0];
	end

	// Field extraction
	always_comb begin
		low_len    = state_r.ch2_phase_lengths[
			output_channel_divider_pkg::LEN_LOW_MSB:
			output_channel_divider_pkg::LEN_LOW_LSB];
		high_len   = state_r.ch2_phase_lengths[
			output_channel_divider_pkg::LEN_HIGH_MSB:
			output_channel_divider_pkg::LEN_HIGH_LSB];
		phase_off  = state_r.ch2_divider_control[
			output_channel_divider_pkg::CTL_PHASE_MSB:
			output_channel_divider_pkg::CTL_PHASE_LSB];
		bypass     = state_r.ch2_divider_control[
			output_channel_divider_pkg::CTL_BYPASS_BIT];
		no_align   = state_r.ch2_divider_control[
			output_channel_divider_pkg::CTL_NOALIGN_BIT];
		force_high = state_r.ch2_divider_control[
			output_channel_divider_pkg::CTL_FORCE_BIT];
		start_high = state_r.ch2_divider_control[
			output_channel_divider_pkg::CTL_START_BIT];
		phase_last = phase_off - 4'h1;
	end

	// Source and route selection
	always_comb begin
		// VCO wins over the divider bypass, so one setting excludes the
		// other and the VCO is only ever passed unbypassed
		if (state_r.input_select[output_channel_divider_pkg::INSEL_VCO_BIT])
		begin
			src_level = vco_in;
		end else if (state_r.input_select[
			output_channel_divider_pkg::INSEL_BYP_BIT]) begin
			src_level = clk_in;
		end else begin
			src_level = vco_div_in;
		end
		// Code 01 and the illegal 11 leave the dividers in charge
		route_vco = (state_r.input_select ==
			output_channel_divider_pkg::INSEL_DIRECT_VCO);
		route_clk = (state_r.input_select ==
			output_channel_divider_pkg::INSEL_DIRECT_CLK);
		// Exempt dividers never see the hold
		held = state_r.align_hold && !no_align;
	end

	// Input select write with the two options kept exclusive
	always_comb begin
		insel_wr = wbyte[1:0];
		if (insel_wr[output_channel_divider_pkg::INSEL_VCO_BIT]) begin
			// Bypass cannot accompany the VCO selection
			insel_wr[output_channel_divider_pkg::INSEL_BYP_BIT] = 1'b0;
		end
	end

	// Next state: registers, divider sequencer, outputs and bus answer
	always_comb begin
		state_nxt = state_r;

		// Register writes take effect only at the committing edge
		if (write_commit && addr_aligned) begin
			if (reg_index ==
				output_channel_divider_pkg::IDX_CH1_ROUTE_DCC) begin
				state_nxt.ch1_route_dcc = wbyte;
			end else if (reg_index ==
				output_channel_divider_pkg::IDX_CH2_PHASE_LENGTHS) begin
				state_nxt.ch2_phase_lengths = wbyte;
			end else if (reg_index ==
				output_channel_divider_pkg::IDX_CH2_DIVIDER_CONTROL) begin
				state_nxt.ch2_divider_control = wbyte;
			end else if (reg_index ==
				output_channel_divider_pkg::IDX_CH2_ROUTE_DCC) begin
				state_nxt.ch2_route_dcc = wbyte;
			end else if (reg_index ==
				output_channel_divider_pkg::IDX_INPUT_SELECT) begin
				state_nxt.input_select = insel_wr;
			end else if (reg_index ==
				output_channel_divider_pkg::IDX_ALIGN_CONTROL) begin
				// A high bit holds; its fall releases the hold
				state_nxt.align_hold = wbyte[0];
			end
		end

		// Divider sequencer; a hold overrides every state
		if (held) begin
			state_nxt.div_state = output_channel_divider_pkg::DIV_HOLD;
			state_nxt.div_cnt   = 4'h0;
		end else begin
			case (state_r.div_state)
				output_channel_divider_pkg::DIV_HOLD: begin
					// Release: offset wait, or start at once
					state_nxt.div_cnt = 4'h0;
					if (phase_off != 4'h0) begin
						state_nxt.div_state =
							output_channel_divider_pkg::DIV_WAIT;
					end else if (start_high) begin
						state_nxt.div_state =
							output_channel_divider_pkg::DIV_HIGH;
					end else begin
						state_nxt.div_state =
							output_channel_divider_pkg::DIV_LOW;
					end
				end
				output_channel_divider_pkg::DIV_WAIT: begin
					// Output delayed by the offset count
					if (state_r.div_cnt >= phase_last) begin
						state_nxt.div_cnt = 4'h0;
						// First level follows the start bit
						state_nxt.div_state = start_high ?
							output_channel_divider_pkg::DIV_HIGH :
							output_channel_divider_pkg::DIV_LOW;
					end else begin
						state_nxt.div_cnt = state_r.div_cnt + 4'h1;
					end
				end
				output_channel_divider_pkg::DIV_LOW: begin
					// Low for field plus one cycles
					if (state_r.div_cnt >= low_len) begin
						state_nxt.div_cnt   = 4'h0;
						state_nxt.div_state =
							output_channel_divider_pkg::DIV_HIGH;
					end else begin
						state_nxt.div_cnt = state_r.div_cnt + 4'h1;
					end
				end
				output_channel_divider_pkg::DIV_HIGH: begin
					// High for field plus one cycles
					if (state_r.div_cnt >= high_len) begin
						state_nxt.div_cnt   = 4'h0;
						state_nxt.div_state =
							output_channel_divider_pkg::DIV_LOW;
					end else begin
						state_nxt.div_cnt = state_r.div_cnt + 4'h1;
					end
				end
				default: begin
					// Lost one-hot code falls back to the hold state
					state_nxt.div_state =
						output_channel_divider_pkg::DIV_HOLD;
					state_nxt.div_cnt   = 4'h0;
				end
			endcase
		end

		// Divider output level; hold and wait show the start level
		case (state_nxt.div_state)
			output_channel_divider_pkg::DIV_HIGH: div_level = 1'b1;
			output_channel_divider_pkg::DIV_LOW:  div_level = 1'b0;
			default:                              div_level = start_high;
		endcase
		if (bypass) begin
			// Input straight through; force has no say here
			state_nxt.div_out = src_level;
		end else if (no_align) begin
			// Exempt divider sits at the forced level
			state_nxt.div_out = force_high;
		end else begin
			state_nxt.div_out = div_level;
		end

		// Pair one: its divider unless the direct route applies
		if (state_r.ch1_route_dcc[
			output_channel_divider_pkg::ROUTE_DIRECT_BIT] && route_vco)
		begin
			state_nxt.pair1.a = vco_in;
		end else if (state_r.ch1_route_dcc[
			output_channel_divider_pkg::ROUTE_DIRECT_BIT] && route_clk)
		begin
			state_nxt.pair1.a = clk_in;
		end else begin
			state_nxt.pair1.a = ch1_div_in;
		end
		state_nxt.pair1.b = !state_nxt.pair1.a;

		// Pair two: same choice against the third divider
		if (state_r.ch2_route_dcc[
			output_channel_divider_pkg::ROUTE_DIRECT_BIT] && route_vco)
		begin
			state_nxt.pair2.a = vco_in;
		end else if (state_r.ch2_route_dcc[
			output_channel_divider_pkg::ROUTE_DIRECT_BIT] && route_clk)
		begin
			state_nxt.pair2.a = clk_in;
		end else begin
			state_nxt.pair2.a = state_r.div_out;
		end
		state_nxt.pair2.b = !state_nxt.pair2.a;

		// Duty-cycle correction disables follow bit zero
		state_nxt.dcc_disable = {
			state_r.ch2_route_dcc[
				output_channel_divider_pkg::ROUTE_DCC_OFF_BIT],
			state_r.ch1_route_dcc[
				output_channel_divider_pkg::ROUTE_DCC_OFF_BIT]};

		// Bus answer prepared in setup, shown during the access phase
		state_nxt.pready  = setup_phase;
		state_nxt.pslverr = 1'b0;
		state_nxt.prdata  = 32'h0;
		if (setup_phase) begin
			if (!addr_aligned) begin
				// Misaligned access is refused
				state_nxt.pslverr = 1'b1;
			end else if (reg_index ==
				output_channel_divider_pkg::IDX_CH1_ROUTE_DCC) begin
				state_nxt.prdata[7:0] = state_r.ch1_route_dcc;
			end else if (reg_index ==
				output_channel_divider_pkg::IDX_CH2_PHASE_LENGTHS) begin
				state_nxt.prdata[7:0] = state_r.ch2_phase_lengths;
			end else if (reg_index ==
				output_channel_divider_pkg::IDX_CH2_DIVIDER_CONTROL) begin
				state_nxt.prdata[7:0] = state_r.ch2_divider_control;
			end else if (reg_index ==
				output_channel_divider_pkg::IDX_CH2_ROUTE_DCC) begin
				state_nxt.prdata[7:0] = state_r.ch2_route_dcc;
			end else if (reg_index ==
				output_channel_divider_pkg::IDX_INPUT_SELECT) begin
				state_nxt.prdata[1:0] = state_r.input_select;
			end else if (reg_index ==
				output_channel_divider_pkg::IDX_ALIGN_CONTROL) begin
				state_nxt.prdata[0] = state_r.align_hold;
			end else if (reg_index ==
				output_channel_divider_pkg::IDX_DIVIDER_STATUS) begin
				// Live view: divider level, hold, sequencer state
				state_nxt.prdata[5:0] = {state_r.div_state, held,
					state_r.div_out};
			end else begin
				// Unmapped address answers with an error
				state_nxt.pslverr = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r.ch1_route_dcc <=
				output_channel_divider_pkg::RST_ROUTE_DCC;
			state_r.ch2_phase_lengths <=
				output_channel_divider_pkg::RST_LENGTHS;
			state_r.ch2_divider_control <=
				output_channel_divider_pkg::RST_CONTROL;
			state_r.ch2_route_dcc <=
				output_channel_divider_pkg::RST_ROUTE_DCC;
			state_r.input_select <= output_channel_divider_pkg::RST_INSEL;
			state_r.align_hold   <= output_channel_divider_pkg::RST_ALIGN;
			// Leaving reset acts as one alignment release
			state_r.div_state <= output_channel_divider_pkg::DIV_HOLD;
			state_r.div_cnt   <= 4'h0;
			state_r.div_out   <= 1'b0;
			state_r.pair1     <= '{a: 1'b0, b: 1'b1};
			state_r.pair2     <= '{a: 1'b0, b: 1'b1};
			state_r.dcc_disable <= 2'h0;
			state_r.prdata    <= 32'h0;
			state_r.pready    <= 1'b0;
			state_r.pslverr   <= 1'b0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Ports straight from the state flops
	assign prdata                  = state_r.prdata;
	assign pready                  = state_r.pready;
	assign pslverr                 = state_r.pslverr;
	assign pair1_out_a             = state_r.pair1.a;
	assign pair1_out_b             = state_r.pair1.b;
	assign pair2_out_a             = state_r.pair2.a;
	assign pair2_out_b             = state_r.pair2.b;
	assign duty_correction_disable = state_r.dcc_disable;

endmodule // output_channel_divider

//--- output_channel_divider_chk.sv
// Port-level assertion checker for the output channel divider
`timescale 1ns/1ps
module output_channel_divider_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        vco_in,
	input wire logic        clk_in,
	input wire logic        vco_div_in,
	input wire logic        ch1_div_in,
	input wire logic        pair1_out_a,
	input wire logic        pair1_out_b,
	input wire logic        pair2_out_a,
	input wire logic        pair2_out_b,
	input wire logic [1:0]  duty_correction_disable
);
	logic [1:0] insel_r;  // Shadow of the input select field
	logic       direct_r; // Shadow of the pair one direct bit
	logic       dcc_r;    // Shadow of the pair one correction bit
	logic       wr;       // Committed write this cycle
	logic [9:0] idx;      // Word index of the access
	assign idx = paddr[11:2];
	assign wr = psel && penable && pready && pwrite && !pslverr;
	// Shadows follow committed writes, so routing can be predicted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			insel_r  <= 2'h0;
			direct_r <= 1'b0;
			dcc_r    <= 1'b0;
		end else if (wr &&
			idx == output_channel_divider_pkg::IDX_INPUT_SELECT) begin
			// Choosing the VCO drops the bypass bit
			insel_r <= pwdata[1] ? 2'h2 : pwdata[1:0];
		end else if (wr &&
			idx == output_channel_divider_pkg::IDX_CH1_ROUTE_DCC) begin
			direct_r <= pwdata[1];
			dcc_r    <= pwdata[0];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_pair1_compl: assert property (pair1_out_b == !pair1_out_a)
		else $error("pair one outputs not complementary");
	a_pair2_compl: assert property (pair2_out_b == !pair2_out_a)
		else $error("pair two outputs not complementary");
	a_ready_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	a_dcc_follow: assert property (
		duty_correction_disable[0] == $past(dcc_r))
		else $error("correction disable does not follow register");
	a_direct_vco: assert property (
		direct_r && insel_r == 2'h2 |=> pair1_out_a == $past(vco_in))
		else $error("pair one not on vco");
	a_direct_clk: assert property (
		direct_r && insel_r == 2'h0 |=> pair1_out_a == $past(clk_in))
		else $error("pair one not on clock input");
	a_div_path: assert property (
		!direct_r || insel_r[0] |=> pair1_out_a == $past(ch1_div_in))
		else $error("pair one not on its divider");
	c_err: cover property (pslverr);
	c_vco: cover property (direct_r && insel_r == 2'h2);
	c_align: cover property (
		wr && idx == output_channel_divider_pkg::IDX_ALIGN_CONTROL);
endmodule // output_channel_divider_chk

bind output_channel_divider output_channel_divider_chk u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .vco_in(vco_in), .clk_in(clk_in),
	.vco_div_in(vco_div_in), .ch1_div_in(ch1_div_in),
	.pair1_out_a(pair1_out_a), .pair1_out_b(pair1_out_b),
	.pair2_out_a(pair2_out_a), .pair2_out_b(pair2_out_b),
	.duty_correction_disable(duty_correction_disable));

//--- test_output_channel_divider.sv
// Self-checking testbench for the output channel divider
`timescale 1ns/1ps
module test_output_channel_divider;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, vco_in, clk_in, vco_div_in, ch1_div_in;
	logic        p1a, p1b, p2a, p2b;
	logic [1:0]  dcc;
	int          num_errors, checks, n0, n3;
	output_channel_divider u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .vco_in(vco_in),
		.clk_in(clk_in), .vco_div_in(vco_div_in), .ch1_div_in(ch1_div_in),
		.pair1_out_a(p1a), .pair1_out_b(p1b), .pair2_out_a(p2a),
		.pair2_out_b(p2b), .duty_correction_disable(dcc));
	// 200 MHz clock
	always #2.5 pclk = ~pclk;
	// Closing verdict
	task automatic results;
		if (num_errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Compare seen against expected
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// One APB transfer; idles one cycle after so strobes never re-assert
	task automatic apb(input logic w, input logic [9:0] i,
		input logic [7:0] d, output logic [31:0] r, output logic er);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			num_errors++;
			results();
		end
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [9:0] i, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, i, d, r, e);
	endtask
	task automatic rdx(input logic [9:0] i, input logic [7:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, i, 8'h0, r, e);
		chk(r, {24'h0, x});
	endtask
	// Count cycles that pair two output a stays at level v
	task automatic run(input logic v, output int n);
		n = 0;
		while (p2a === v && n < 100) begin
			@(posedge pclk);
			n++;
		end
		// A level that never ends is a hang and counts as a mismatch
		if (n >= 100) begin
			num_errors++;
			results();
		end
	endtask
	// Reset values, read back, unmapped access
	task automatic t_regs;
		logic [31:0] r;
		logic e;
		rdx(output_channel_divider_pkg::IDX_CH2_PHASE_LENGTHS, 8'h0);
		rdx(output_channel_divider_pkg::IDX_CH2_DIVIDER_CONTROL, 8'h0);
		wr(output_channel_divider_pkg::IDX_INPUT_SELECT, 8'h3);
		rdx(output_channel_divider_pkg::IDX_INPUT_SELECT, 8'h2);
		apb(1'b0, 10'h100, 8'h0, r, e);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
	endtask
	// Low and high phase lengths
	task automatic t_len;
		int h, l;
		wr(output_channel_divider_pkg::IDX_CH2_PHASE_LENGTHS, 8'h21);
		// Skip four level runs so old-length phases are flushed
		run(1'b1, h);
		run(1'b0, h);
		run(1'b1, h);
		run(1'b0, h);
		run(1'b1, h);
		run(1'b0, l);
		chk(32'(h), 32'h2);
		chk(32'(l), 32'h3);
	endtask
	// Forced level, exemption and bypass
	task automatic t_force;
		int n;
		wr(output_channel_divider_pkg::IDX_CH2_DIVIDER_CONTROL, 8'h60);
		repeat (3) @(posedge pclk);
		chk({31'h0, p2a}, 32'h1);
		wr(output_channel_divider_pkg::IDX_ALIGN_CONTROL, 8'h1);
		repeat (3) @(posedge pclk);
		chk({31'h0, p2a}, 32'h1);
		wr(output_channel_divider_pkg::IDX_ALIGN_CONTROL, 8'h0);
		// Force without exemption must leave the divider toggling
		wr(output_channel_divider_pkg::IDX_CH2_DIVIDER_CONTROL, 8'h20);
		run(1'b1, n);
		run(1'b0, n);
		run(1'b1, n);
		run(1'b0, n);
		chk(32'(n), 32'h3);
		// Select code 00 feeds the VCO divider input to the bypass
		wr(output_channel_divider_pkg::IDX_INPUT_SELECT, 8'h0);
		wr(output_channel_divider_pkg::IDX_CH2_DIVIDER_CONTROL, 8'he0);
		vco_div_in <= 1'b0;
		repeat (3) @(posedge pclk);
		chk({31'h0, p2a}, 32'h0);
		vco_div_in <= 1'b1;
		repeat (3) @(posedge pclk);
		chk({31'h0, p2a}, 32'h1);
	endtask
	// Hold at start level, then release after the phase offset
	task automatic t_sync(input logic st, input logic [3:0] off,
		output int n);
		wr(output_channel_divider_pkg::IDX_CH2_DIVIDER_CONTROL,
			{3'h0, st, off});
		wr(output_channel_divider_pkg::IDX_ALIGN_CONTROL, 8'h1);
		repeat (4) @(posedge pclk);
		chk({31'h0, p2a}, {31'h0, st});
		wr(output_channel_divider_pkg::IDX_ALIGN_CONTROL, 8'h0);
		run(st, n);
	endtask
	// Direct routes and correction disables for select codes 00, 01 and 10
	task automatic t_route;
		logic [1:0] c;
		logic x;
		wr(output_channel_divider_pkg::IDX_CH1_ROUTE_DCC, 8'h3);
		wr(output_channel_divider_pkg::IDX_CH2_ROUTE_DCC, 8'h3);
		// Disable outputs trail the register by one cycle
		@(posedge pclk);
		chk({30'h0, dcc}, 32'h3);
		for (int v = 0; v < 2; v++) begin
			for (int k = 0; k < 3; k++) begin
				c = 2'(k);
				wr(output_channel_divider_pkg::IDX_INPUT_SELECT, {6'h0, c});
				vco_in <= v[0];
				clk_in <= !v[0];
				// Divider level differs from the routed source
				ch1_div_in <= (c == 2'h0) ? v[0] : !v[0];
				repeat (3) @(posedge pclk);
				x = (c == 2'h2) ? v[0] : !v[0];
				chk({31'h0, p1a}, {31'h0, x});
				if (c != 2'h1) chk({31'h0, p2a}, {31'h0, x});
			end
		end
		wr(output_channel_divider_pkg::IDX_CH1_ROUTE_DCC, 8'h0);
		wr(output_channel_divider_pkg::IDX_CH2_ROUTE_DCC, 8'h1);
		ch1_div_in <= 1'b0;
		repeat (3) @(posedge pclk);
		chk({31'h0, p1a}, 32'h0);
		chk({30'h0, dcc}, 32'h2);
	endtask
	// Main sequence
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, vco_in, clk_in, vco_div_in} = 6'h0;
		ch1_div_in = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		num_errors = 0;
		checks = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_len();
		t_force();
		t_sync(1'b0, 4'h0, n0);
		t_sync(1'b1, 4'h0, n0);
		t_sync(1'b1, 4'h3, n3);
		chk(32'(n3 - n0), 32'h3);
		t_route();
		results();
	end
endmodule // test_output_channel_divider
